// *** design/rwcm_pkg.sv ***
/*
 Shared constants of the reset, watchdog and clock monitor block.
 Assumes a 50 MHz pclk and an 8-bit APB address with word-aligned registers.
*/
package rwcm_pkg;
    // Bus and clock
    localparam int ADDR_W = 8;
    localparam int CLK_PERIOD_NS = 20;
    // Register indexes, byte address is four times the index
    localparam logic [5:0] SERVICE_IDX = 6'h1d;
    localparam logic [5:0] CONTROL_IDX = 6'h1e;
    // Control register fields
    localparam int PERIOD_LO_BIT = 0;
    localparam int PERIOD_HI_BIT = 1;
    localparam int WDOG_ON_BIT = 2;
    localparam int CMON_ON_BIT = 3;
    localparam int FLAG_BIT = 4;
    localparam logic [7:0] CONTROL_WMASK = 8'h0f;
    // Service keys
    localparam logic [7:0] KEY_ARM = 8'h55;
    localparam logic [7:0] KEY_FIRE = 8'haa;
    // Reset timing
    localparam int POR_CYCLES = 4064;
    localparam int PIN_DRIVE_CYCLES = 4;
    localparam int CMON_TIMEOUT_NS = 100000;
    localparam int CMON_CYCLES = CMON_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int WDOG_BASE_TICKS = 32768;
    localparam int WDOG_CNT_W = 22;
    // Restart vector
    localparam logic [12:0] VEC_HI_ADDR = 13'h1ffe;
    localparam logic [12:0] VEC_LO_ADDR = 13'h1fff;
    // Reset-time state for processor and peripherals
    localparam logic [12:0] SP_RESET = 13'h00ff;
    localparam logic [15:0] TIMER_RESET = 16'hfffc;
    localparam logic [7:0] DDR_RESET = 8'h00;
    localparam logic [7:0] SCI_CTRL_RESET = 8'h00;
    localparam logic [7:0] SCI_STAT_RESET = 8'hc0;
    localparam logic [7:0] SPI_CTRL_RESET = 8'h00;
    localparam logic [7:0] TIMER_CTRL_RESET = 8'h00;
    // Sequencer states
    typedef enum logic [2:0] {
        RWCM_POR = 3'b000,
        RWCM_DRIVE = 3'b001,
        RWCM_HOLD = 3'b010,
        RWCM_VEC_HI = 3'b011,
        RWCM_VEC_LO = 3'b100,
        RWCM_VEC_END = 3'b101,
        RWCM_RUN = 3'b110
    } rwcm_state_e;
endpackage : rwcm_pkg

// *** design/rwcm_top.sv ***
/*
 Reset sequencer with software watchdog, clock monitor and APB registers.
 Assumes all inputs synchronous to pclk; presetn is the power-on reset and
 the reset pin is open drain with the level returned on reset_pin_in.
*/
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps

module rwcm_top #(
    parameter int CMON_LIMIT = rwcm_pkg::CMON_CYCLES,
    parameter int WDOG_BASE = rwcm_pkg::WDOG_BASE_TICKS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rwcm_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic bus_clk_in,
    input wire logic stop_entry,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe_n,
    output logic sys_reset_n,
    output logic [12:0] vec_addr,
    output logic vec_rd,
    input wire logic [7:0] vec_data,
    output logic [12:0] pc_start,
    output logic [12:0] sp_load,
    output logic irq_mask_set,
    output logic [7:0] ddr_load,
    output logic [7:0] sci_ctrl_load,
    output logic [7:0] sci_stat_load,
    output logic [7:0] spi_ctrl_load,
    output logic [15:0] timer_load,
    output logic [7:0] timer_ctrl_load
);
    import rwcm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    rwcm_state_e state_reg, state_next;
    logic [11:0] cnt_reg, cnt_next;
    logic [7:0] ctrl_reg;
    logic flag_reg;
    logic armed_reg;
    logic [WDOG_CNT_W-1:0] wd_cnt_reg;
    logic [12:0] gap_reg;
    logic bus_clk_prev_reg;
    logic [7:0] pc_hi_reg;
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] idx);
        hit = (a[ADDR_W-1:2] == idx) && (a[1:0] == 2'b00);
    endfunction : hit
    function automatic logic [WDOG_CNT_W-1:0] wd_limit(input logic [1:0] code);
        wd_limit = WDOG_CNT_W'(WDOG_BASE) << {code, 1'b0};
    endfunction : wd_limit

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    wire setup = psel && !penable;
    wire access = psel && penable && pready;
    wire svc_hit = hit(paddr, SERVICE_IDX);
    wire ctl_hit = hit(paddr, CONTROL_IDX);
    wire wr_svc = access && pwrite && svc_hit;
    wire wr_ctl = access && pwrite && ctl_hit;
    wire rd_ctl = access && !pwrite && ctl_hit;
    wire [7:0] ctl_view = {3'b000, flag_reg, ctrl_reg[3:0]};
    wire in_run = (state_reg == RWCM_RUN);

    ////////////////////////////////////////////////////////////////////////
    // Fault detection
    wire bus_clk_edge = bus_clk_in && !bus_clk_prev_reg;
    wire [1:0] period = {ctrl_reg[PERIOD_HI_BIT], ctrl_reg[PERIOD_LO_BIT]};
    wire wd_restart = wr_svc && armed_reg && (pwdata[7:0] == KEY_FIRE);
    wire wd_expire = bus_clk_edge && (wd_cnt_reg == wd_limit(period) - 1'b1);
    wire wd_fail = in_run && ctrl_reg[WDOG_ON_BIT] && wd_expire && !wd_restart;
    wire cm_fail = in_run && ctrl_reg[CMON_ON_BIT] && (gap_reg >= 13'(CMON_LIMIT));
    wire stop_fail = in_run && ctrl_reg[CMON_ON_BIT] && stop_entry;
    wire int_fail = wd_fail || cm_fail || stop_fail;
    wire ext_low = !reset_pin_in;

    ////////////////////////////////////////////////////////////////////////
    // Reset sequencer
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg + 12'h001;
        case (state_reg)
            RWCM_POR:
            begin
                if (cnt_reg == 12'(POR_CYCLES - 1))
                begin
                    state_next = RWCM_HOLD;
                end
            end
            RWCM_DRIVE:
            begin
                if (cnt_reg == 12'(PIN_DRIVE_CYCLES - 1))
                begin
                    state_next = RWCM_HOLD;
                end
            end
            RWCM_HOLD:
            begin
                if (!ext_low)
                begin
                    state_next = RWCM_VEC_HI;
                end
            end
            RWCM_VEC_HI:
            begin
                state_next = ext_low ? RWCM_HOLD : RWCM_VEC_LO;
            end
            RWCM_VEC_LO:
            begin
                state_next = ext_low ? RWCM_HOLD : RWCM_VEC_END;
            end
            RWCM_VEC_END:
            begin
                state_next = ext_low ? RWCM_HOLD : RWCM_RUN;
            end
            RWCM_RUN:
            begin
                if (ext_low)
                begin
                    state_next = RWCM_HOLD;
                end
                else if (int_fail)
                begin
                    state_next = RWCM_DRIVE;
                end
            end
            default:
            begin
                state_next = RWCM_POR;
            end
        endcase
        if (state_next != state_reg)
        begin
            cnt_next = 12'h000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= RWCM_POR;
            cnt_reg <= 12'h000;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin, system reset and vector fetch
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            reset_pin_out <= 1'b1;
            reset_pin_oe_n <= 1'b1;
            sys_reset_n <= 1'b0;
            vec_rd <= 1'b0;
            vec_addr <= VEC_HI_ADDR;
            pc_hi_reg <= 8'h00;
            pc_start <= 13'h0000;
        end
        else
        begin
            reset_pin_out <= (state_next != RWCM_DRIVE);
            reset_pin_oe_n <= (state_next != RWCM_DRIVE);
            sys_reset_n <= (state_next == RWCM_RUN);
            vec_rd <= (state_next == RWCM_VEC_HI) || (state_next == RWCM_VEC_LO);
            vec_addr <= (state_next == RWCM_VEC_LO) ? VEC_LO_ADDR : VEC_HI_ADDR;
            if (state_reg == RWCM_VEC_LO)
            begin
                pc_hi_reg <= vec_data;
            end
            if (state_reg == RWCM_VEC_END)
            begin
                pc_start <= {pc_hi_reg[4:0], vec_data};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset-time state handed to processor and peripherals
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sp_load <= SP_RESET;
            irq_mask_set <= 1'b1;
            ddr_load <= DDR_RESET;
            sci_ctrl_load <= SCI_CTRL_RESET;
            sci_stat_load <= SCI_STAT_RESET;
            spi_ctrl_load <= SPI_CTRL_RESET;
            timer_load <= TIMER_RESET;
            timer_ctrl_load <= TIMER_CTRL_RESET;
        end
        else
        begin
            sp_load <= SP_RESET;
            irq_mask_set <= (state_next != RWCM_RUN);
            ddr_load <= DDR_RESET;
            sci_ctrl_load <= SCI_CTRL_RESET;
            sci_stat_load <= SCI_STAT_RESET;
            spi_ctrl_load <= SPI_CTRL_RESET;
            timer_load <= TIMER_RESET;
            timer_ctrl_load <= TIMER_CTRL_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register and cause flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= 8'h00;
            flag_reg <= 1'b0;
        end
        else
        begin
            if (wr_ctl)
            begin
                ctrl_reg <= pwdata[7:0] & CONTROL_WMASK;
            end
            if (!in_run || int_fail || ext_low)
            begin
                ctrl_reg[PERIOD_HI_BIT] <= 1'b0;
                ctrl_reg[PERIOD_LO_BIT] <= 1'b0;
            end
            // cause flag, set beats read clear
            if (int_fail)
            begin
                flag_reg <= 1'b1;
            end
            else if (in_run && ext_low)
            begin
                flag_reg <= 1'b0;
            end
            else if (rd_ctl)
            begin
                flag_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog and clock monitor counters
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            armed_reg <= 1'b0;
            wd_cnt_reg <= '0;
            gap_reg <= 13'h0000;
            bus_clk_prev_reg <= 1'b0;
        end
        else
        begin
            bus_clk_prev_reg <= bus_clk_in;
            if (wr_svc)
            begin
                armed_reg <= (pwdata[7:0] == KEY_ARM);
            end
            if (!in_run || wd_restart || wd_expire)
            begin
                wd_cnt_reg <= '0;
            end
            else if (bus_clk_edge)
            begin
                wd_cnt_reg <= wd_cnt_reg + 1'b1;
            end
            if (!in_run || bus_clk_edge || !ctrl_reg[CMON_ON_BIT])
            begin
                gap_reg <= 13'h0000;
            end
            else if (gap_reg != 13'h1fff)
            begin
                gap_reg <= gap_reg + 13'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave, one wait-free access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup && !svc_hit && !ctl_hit;
            prdata <= (setup && ctl_hit && !pwrite) ? {24'h000000, ctl_view} : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    por_delay_a: assert property (
        $rose(presetn) |-> !sys_reset_n [*8]
    ) else $error("Reset released early after power-on");
    pin_drive_a: assert property (
        (state_reg == RWCM_RUN && state_next == RWCM_DRIVE)
        |=> !reset_pin_oe_n [*4] ##1 reset_pin_oe_n
    ) else $error("Reset pin not driven for four cycles");
    pin_hold_a: assert property (
        (state_reg == RWCM_HOLD && !reset_pin_in) |=> !sys_reset_n
    ) else $error("Left reset while pin low");
    cause_set_a: assert property (
        int_fail |=> flag_reg
    ) else $error("Cause flag not set on internal reset");
    read_clear_a: assert property (
        (rd_ctl && !int_fail && in_run) |=> !flag_reg
    ) else $error("Control read did not clear cause flag");
    wd_gate_a: assert property (
        (in_run && !ctrl_reg[WDOG_ON_BIT] && !cm_fail && !stop_fail && reset_pin_in)
        |=> state_reg == RWCM_RUN
    ) else $error("Watchdog reset while disabled");
    key_pair_a: assert property (
        (wr_svc && !armed_reg && in_run && !bus_clk_edge) |=> $stable(wd_cnt_reg)
    ) else $error("Unpaired key restarted watchdog");
    stop_reset_a: assert property (
        stop_fail && reset_pin_in |=> state_reg == RWCM_DRIVE
    ) else $error("Stop with monitor on gave no reset");
    vector_a: assert property (
        (state_reg == RWCM_VEC_HI && reset_pin_in) |=> vec_rd && vec_addr == VEC_LO_ADDR
    ) else $error("Restart vector fetch out of order");
    period_clr_a: assert property (
        (state_reg == RWCM_DRIVE) |-> period == 2'b00
    ) else $error("Period bits not cleared in reset");

    wd_reset_c: cover property (wd_fail ##[1:20] sys_reset_n);
    cm_reset_c: cover property (cm_fail);
    ext_reset_c: cover property (in_run && ext_low);
    key_seq_c: cover property (wd_restart);

endmodule : rwcm_top

// *** verification/rwcm_top_bench.sv ***
/*
 Self-checking bench for the reset, watchdog and clock monitor block.
 Assumes rwcm_pkg and rwcm_top are compiled first; pin pulled up outside.
*/
`timescale 1ns/1ps
module rwcm_top_bench;
    import rwcm_pkg::*;
    localparam int CML = 20;
    localparam int WDB = 8;
    localparam logic [7:0] A_SVC = {SERVICE_IDX, 2'b00};
    localparam logic [7:0] A_CTL = {CONTROL_IDX, 2'b00};
    localparam logic [7:0] A_BAD = 8'h40;
    localparam logic [7:0] V_HI = 8'h15;
    localparam logic [7:0] V_LO = 8'h3c;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, ddr_load, sci_ctrl_load, sci_stat_load;
    logic [7:0] vec_data = 8'h00;
    logic bus_clk_in = 1'b0;
    logic [7:0] spi_ctrl_load, timer_ctrl_load;
    logic [31:0] pwdata, prdata;
    logic bus_run, stop_entry, ext_pin, pin_level;
    logic reset_pin_out, reset_pin_oe_n, sys_reset_n, vec_rd, irq_mask_set;
    logic [12:0] vec_addr, pc_start, sp_load;
    logic [15:0] timer_load;
    int n_fail = 0;
    int checks = 0;
    int n, m;
    rwcm_top #(.CMON_LIMIT(CML), .WDOG_BASE(WDB)) i_rwcm_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bus_clk_in(bus_clk_in),
        .stop_entry(stop_entry), .reset_pin_in(pin_level),
        .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n),
        .sys_reset_n(sys_reset_n), .vec_addr(vec_addr), .vec_rd(vec_rd),
        .vec_data(vec_data), .pc_start(pc_start), .sp_load(sp_load),
        .irq_mask_set(irq_mask_set), .ddr_load(ddr_load),
        .sci_ctrl_load(sci_ctrl_load), .sci_stat_load(sci_stat_load),
        .spi_ctrl_load(spi_ctrl_load), .timer_load(timer_load),
        .timer_ctrl_load(timer_ctrl_load)
    );
    ////////////////////////////////////////////////////////////////////////
    // Open-drain pin, bus clock and vector memory
    assign pin_level = (reset_pin_oe_n === 1'b0) ? reset_pin_out : ext_pin;
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        if (bus_run)
            bus_clk_in <= ~bus_clk_in;
        if (vec_rd === 1'b1)
            vec_data <= (vec_addr === VEC_HI_ADDR) ? V_HI : V_LO;
    end
    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic eerr);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        check({31'h0, pready}, 32'h1);
        if (!w)
            check(prdata, exp);
        check({31'h0, pslverr}, {31'h0, eerr});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : acc
    task automatic service();
        acc(1'b1, A_SVC, {24'h0, KEY_ARM}, 32'h0, 1'b0);
        acc(1'b1, A_SVC, {24'h0, KEY_FIRE}, 32'h0, 1'b0);
    endtask : service
    task automatic wait_run(input int lim, output int k);
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (sys_reset_n !== 1'b1 && k < lim);
    endtask : wait_run
    task automatic wait_oe(input int lim, output int k);
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (reset_pin_oe_n !== 1'b0 && k < lim);
    endtask : wait_oe
    task automatic oe_low(output int k);
        k = 0;
        while (reset_pin_oe_n === 1'b0 && k < 20)
        begin
            @(posedge pclk);
            k++;
        end
    endtask : oe_low
    function automatic logic [31:0] inr(input int v, input int lo, input int hi);
        return {31'h0, v >= lo && v <= hi};
    endfunction : inr
    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    // power-on hold
    task automatic t_power_on();
        presetn <= 1'b0;
        ext_pin <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (POR_CYCLES + 40) @(posedge pclk);
        check({31'h0, sys_reset_n}, 32'h0);
        check({18'h0, sp_load, irq_mask_set}, {18'h0, 13'h00ff, 1'b1});
        check({24'h0, ddr_load}, 32'h0);
        check({16'h0, sci_ctrl_load, sci_stat_load}, {16'h0, 8'h00, SCI_STAT_RESET});
        check({24'h0, spi_ctrl_load}, 32'h0);
        check({8'h0, timer_load, timer_ctrl_load}, {8'h0, 16'hfffc, 8'h00});
        ext_pin <= 1'b1;
        wait_run(50, n);
        check({19'h0, pc_start}, {19'h0, V_HI[4:0], V_LO});
        acc(1'b0, A_CTL, 32'h0, 32'h0, 1'b0);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        wait_run(POR_CYCLES + 100, n);
        check(inr(n, POR_CYCLES, POR_CYCLES + 10), 32'h1);
        $display("power-on test done");
    endtask : t_power_on
    task automatic t_regs();
        acc(1'b1, A_CTL, 32'hf8, 32'h0, 1'b0);
        acc(1'b0, A_CTL, 32'h0, 32'h08, 1'b0);
        acc(1'b1, A_CTL, 32'h00, 32'h0, 1'b0);
        acc(1'b0, A_CTL, 32'h0, 32'h00, 1'b0);
        acc(1'b0, A_SVC, 32'h0, 32'h00, 1'b0);
        acc(1'b0, A_BAD, 32'h0, 32'h00, 1'b1);
        acc(1'b1, A_BAD, 32'h55, 32'h0, 1'b1);
        repeat (100) @(posedge pclk);
        check({31'h0, sys_reset_n}, 32'h1);
        $display("register test done");
    endtask : t_regs
    task automatic t_periods();
        for (int c = 0; c < 4; c++)
        begin
            service();
            acc(1'b1, A_CTL, 32'h04 | c, 32'h0, 1'b0);
            wait_oe(3000, n);
            check({30'h0, reset_pin_out, pin_level}, 32'h0);
            check(inr(n, 2 * WDB * (1 << (2 * c)) - 8, 2 * WDB * (1 << (2 * c)) + 4), 1);
            oe_low(m);
            check(m, 4);
            wait_run(50, n);
            acc(1'b0, A_CTL, 32'h0, 32'h14, 1'b0);
            acc(1'b1, A_CTL, 32'h00, 32'h0, 1'b0);
            acc(1'b0, A_CTL, 32'h0, 32'h00, 1'b0);
        end
        $display("period test done");
    endtask : t_periods
    task automatic t_keys();
        service();
        acc(1'b1, A_CTL, 32'h07, 32'h0, 1'b0);
        repeat (3)
        begin
            repeat (600) @(posedge pclk);
            acc(1'b1, A_SVC, 32'h55, 32'h0, 1'b0);
            acc(1'b0, A_BAD, 32'h0, 32'h0, 1'b1);
            acc(1'b0, A_CTL, 32'h0, 32'h07, 1'b0);
            acc(1'b1, A_SVC, 32'haa, 32'h0, 1'b0);
        end
        check({31'h0, sys_reset_n}, 32'h1);
        acc(1'b1, A_SVC, 32'h55, 32'h0, 1'b0);
        acc(1'b1, A_SVC, 32'h12, 32'h0, 1'b0);
        acc(1'b1, A_SVC, 32'haa, 32'h0, 1'b0);
        wait_oe(1100, n);
        check(inr(n, 1008, 1020), 32'h1);
        wait_run(50, n);
        acc(1'b0, A_CTL, 32'h0, 32'h14, 1'b0);
        acc(1'b1, A_CTL, 32'h00, 32'h0, 1'b0);
        $display("key test done");
    endtask : t_keys
    task automatic t_cmon();
        acc(1'b1, A_CTL, 32'h08, 32'h0, 1'b0);
        bus_run <= 1'b0;
        wait_oe(200, n);
        check({30'h0, reset_pin_out, pin_level}, 32'h0);
        check(inr(n, CML - 4, CML + 6), 32'h1);
        bus_run <= 1'b1;
        oe_low(m);
        check(m, 4);
        wait_run(50, n);
        check({19'h0, pc_start}, {19'h0, V_HI[4:0], V_LO});
        ext_pin <= 1'b0;
        repeat (5) @(posedge pclk);
        check({31'h0, sys_reset_n}, 32'h0);
        ext_pin <= 1'b1;
        wait_run(50, n);
        acc(1'b0, A_CTL, 32'h0, 32'h08, 1'b0);
        stop_entry <= 1'b1;
        @(posedge pclk);
        stop_entry <= 1'b0;
        wait_oe(20, n);
        check(inr(n, 1, 10), 32'h1);
        wait_run(50, n);
        acc(1'b0, A_CTL, 32'h0, 32'h18, 1'b0);
        acc(1'b1, A_CTL, 32'h00, 32'h0, 1'b0);
        stop_entry <= 1'b1;
        @(posedge pclk);
        stop_entry <= 1'b0;
        repeat (20) @(posedge pclk);
        check({31'h0, sys_reset_n}, 32'h1);
        $display("clock monitor test done");
    endtask : t_cmon
    ////////////////////////////////////////////////////////////////////////
    // Verdict, watchdog and main sequence
    task automatic conclude();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    initial
    begin
        #(60000 * 20);
        n_fail++;
        conclude();
    end
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        bus_run = 1'b1;
        stop_entry = 1'b0;
        ext_pin = 1'b1;
        t_power_on();
        t_regs();
        t_periods();
        t_keys();
        t_cmon();
        conclude();
    end
endmodule : rwcm_top_bench
